// file: shared/dft_pkg.sv
// Package for the decimation filter and output timing block
package dft_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] DFT_OFS_CTRL = 8'h00;
    localparam logic [7:0] DFT_OFS_DECIM = 8'h04;
    localparam logic [7:0] DFT_OFS_STATUS = 8'h08;
    localparam logic [7:0] DFT_OFS_RESULT = 8'h0c;

    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int DFT_CTRL_SPEED_BIT = 0;
    localparam int DFT_CTRL_FILT_LSB = 1;
    localparam int DFT_CTRL_GAIN_LSB = 3;
    localparam int DFT_CTRL_CHAN_LSB = 6;
    localparam int DFT_CTRL_EN_BIT = 9;
    localparam int DFT_CTRL_W = 10;
    localparam logic [9:0] DFT_CTRL_RST = 10'h000;

    // Status fields: bit 0 overrun (write 1 to clear), bits 2:1 buffer level
    localparam int DFT_STAT_OVR_BIT = 0;
    localparam int DFT_STAT_LVL_LSB = 1;

    // ----------------------------------------------------------------
    // Decimation and divisor figures
    // ----------------------------------------------------------------
    localparam logic [10:0] DFT_DECIM_MIN = 11'h014;
    localparam logic [10:0] DFT_DECIM_MAX = 11'h7ff;
    localparam logic [10:0] DFT_DECIM_RST = 11'h014;
    localparam logic [8:0] DFT_DIV_FAST = 9'h080;
    localparam logic [8:0] DFT_DIV_SLOW = 9'h100;
    localparam logic [2:0] DFT_GAIN_CODE_8 = 3'h3;
    localparam logic [2:0] DFT_GAIN_CODE_16 = 3'h4;
    localparam int DFT_SAMP_SHIFT_16 = 3;
    localparam int DFT_SAMP_SHIFT_32 = 4;
    localparam int DFT_SINC3_SHIFT = 4;
    localparam int DFT_ACC_W = 36;

    typedef enum logic [1:0] {
        DFT_FILT_FAST,
        DFT_FILT_SINC2,
        DFT_FILT_SINC3,
        DFT_FILT_AUTO
    } dft_filt_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] filt;
        logic [2:0] chan;
    } dft_res_t;

endpackage : dft_pkg

// file: src/dft_buf.sv
// Small result buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dft_buf
    import dft_pkg::*;
#(
    parameter int W = 37,
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [LW-1:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire [AW-1:0] wptr_inc = (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
    wire [AW-1:0] rptr_inc = (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;

    assign in_ready = (cnt_reg != LW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rptr_reg];
    assign level = cnt_reg;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wptr_reg] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wptr_reg <= wptr_inc;
            if (pop)
                rptr_reg <= rptr_inc;
            cnt_reg <= cnt_reg + LW'(push) - LW'(pop);
        end
    end

    a_buf_no_over: assert property (@(posedge clk) disable iff (!rst_b)
        !in_ready |=> cnt_reg == LW'(DEPTH) || $past(pop))
        else $error("buffer level moved while full without a pop");

endmodule : dft_buf
`default_nettype wire

// file: src/dft_core.sv
// Decimation filter, modulator timing and register slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Modulator tick every 128 or 256 clocks
// R2 - Decimation ratio only 20 to 2047
// R3 - One result per decimation-ratio modulator ticks
// R4 - Fast, sinc2, sinc3 filters settle 1/2/3
// R5 - Auto: fast twice, sinc2 once, then sinc3
// R6 - Positive input gives positive code, negative negative
// R7 - Sampling switch rate scales with gain setting
// R8 - One-cycle valid strobe with each result
module dft_core
    import dft_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mod_bit,
    output logic mod_tick_out,
    output logic samp_tick_out,
    output logic out_strobe,
    output logic res_valid,
    input wire logic res_ready,
    output logic [31:0] res_data,
    output logic [2:0] res_chan
);
    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    logic [DFT_CTRL_W-1:0] ctrl_reg;
    logic [10:0] decim_reg;
    logic ovr_reg;
    logic [31:0] last_reg;
    logic [31:0] hrdata_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [1:0] level;

    wire addr_ok = hsel && hready && htrans[1];
    wire rd_take = addr_ok && !hwrite;
    wire wr_ctrl = wr_pend_reg && (wr_addr_reg == DFT_OFS_CTRL);
    wire wr_decim = wr_pend_reg && (wr_addr_reg == DFT_OFS_DECIM);
    wire wr_stat = wr_pend_reg && (wr_addr_reg == DFT_OFS_STATUS);
    wire [10:0] decim_wdata = hwdata[10:0];
    wire decim_ok = (hwdata[31:11] == '0) && (decim_wdata >= DFT_DECIM_MIN);
    wire [31:0] stat_word = {29'h0, level, ovr_reg};
    wire [31:0] rd_mux =
        (haddr[7:0] == DFT_OFS_CTRL) ? {22'h0, ctrl_reg} :
        (haddr[7:0] == DFT_OFS_DECIM) ? {21'h0, decim_reg} :
        (haddr[7:0] == DFT_OFS_STATUS) ? stat_word :
        (haddr[7:0] == DFT_OFS_RESULT) ? last_reg : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
            if (rd_take)
                hrdata_reg <= rd_mux;
        end
    end

    // Out-of-range ratios are ignored so the old ratio stays in force
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl_reg <= DFT_CTRL_RST;
            decim_reg <= DFT_DECIM_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= hwdata[DFT_CTRL_W-1:0];
            if (wr_decim && decim_ok) // R2
                decim_reg <= decim_wdata;
        end
    end

    wire speed = ctrl_reg[DFT_CTRL_SPEED_BIT];
    wire [1:0] filt_mode = ctrl_reg[DFT_CTRL_FILT_LSB +: 2];
    wire [2:0] gain = ctrl_reg[DFT_CTRL_GAIN_LSB +: 3];
    wire [2:0] chan = ctrl_reg[DFT_CTRL_CHAN_LSB +: 3];
    wire enable = ctrl_reg[DFT_CTRL_EN_BIT];
    // A channel change or disable restarts the filter and the auto sequence
    wire restart = !enable || (wr_ctrl && hwdata[DFT_CTRL_CHAN_LSB +: 3] != chan);

    // ----------------------------------------------------------------
    // Modulator and sampling timing
    // ----------------------------------------------------------------
    logic [8:0] div_cnt_reg;
    logic [8:0] samp_cnt_reg;
    logic mod_bit_s1_reg;
    logic mod_bit_s2_reg;
    logic samp_tick_reg;
    wire [8:0] mod_div = speed ? DFT_DIV_SLOW : DFT_DIV_FAST; // R1
    wire mod_tick = (div_cnt_reg == mod_div - 9'h001);
    wire [8:0] samp_div = (gain <= DFT_GAIN_CODE_8) ? mod_div :
        (gain == DFT_GAIN_CODE_16) ? (mod_div >> DFT_SAMP_SHIFT_16) :
        (mod_div >> DFT_SAMP_SHIFT_32); // R7
    wire samp_hit = (samp_cnt_reg >= samp_div - 9'h001);

    assign mod_tick_out = mod_tick;
    assign samp_tick_out = samp_tick_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_b || restart)
        begin
            div_cnt_reg <= 9'h000;
            samp_cnt_reg <= 9'h000;
            samp_tick_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= mod_tick ? 9'h000 : div_cnt_reg + 9'h001; // R1
            samp_cnt_reg <= samp_hit ? 9'h000 : samp_cnt_reg + 9'h001; // R7
            samp_tick_reg <= samp_hit;
        end
    end

    // Modulator bit arrives from a pin
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mod_bit_s1_reg <= 1'b0;
            mod_bit_s2_reg <= 1'b0;
        end
        else
        begin
            mod_bit_s1_reg <= mod_bit;
            mod_bit_s2_reg <= mod_bit_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Integrators and combs
    // ----------------------------------------------------------------
    // Wrapping arithmetic is exact for the combs as long as the width covers
    // three times the ratio's bit count
    logic signed [DFT_ACC_W-1:0] i1_reg, i2_reg, i3_reg;
    logic signed [DFT_ACC_W-1:0] d1_reg, d2a_reg, d2b_reg, d3a_reg, d3b_reg, d3c_reg;
    logic [10:0] dec_cnt_reg;
    logic [1:0] rd_cnt_reg;
    wire signed [DFT_ACC_W-1:0] x_in = mod_bit_s2_reg ? 36'sh1 : -36'sh1; // R6
    wire out_evt = mod_tick && (dec_cnt_reg == decim_reg - 11'h001); // R3
    // Combs read the integrators after this tick, so the first window after a
    // restart already holds a full ratio of samples
    wire signed [DFT_ACC_W-1:0] y1 = (i1_reg + x_in) - d1_reg; // R4
    wire signed [DFT_ACC_W-1:0] y2a = (i2_reg + i1_reg) - d2a_reg;
    wire signed [DFT_ACC_W-1:0] y2 = y2a - d2b_reg; // R4
    wire signed [DFT_ACC_W-1:0] y3a = (i3_reg + i2_reg) - d3a_reg;
    wire signed [DFT_ACC_W-1:0] y3b = y3a - d3b_reg;
    wire signed [DFT_ACC_W-1:0] y3 = y3b - d3c_reg; // R4
    wire signed [DFT_ACC_W-1:0] y3s = y3 >>> DFT_SINC3_SHIFT;
    wire [1:0] auto_sel = (rd_cnt_reg < 2'h2) ? DFT_FILT_FAST :
        (rd_cnt_reg == 2'h2) ? DFT_FILT_SINC2 : DFT_FILT_SINC3; // R5
    wire [1:0] filt_sel = (filt_mode == DFT_FILT_AUTO) ? auto_sel : filt_mode;
    wire [31:0] y_sel = (filt_sel == DFT_FILT_FAST) ? y1[31:0] :
        (filt_sel == DFT_FILT_SINC2) ? y2[31:0] : y3s[31:0];

    always_ff @(posedge clk)
    begin
        if (!rst_b || restart)
        begin
            {i1_reg, i2_reg, i3_reg} <= '0;
            {d1_reg, d2a_reg, d2b_reg, d3a_reg, d3b_reg, d3c_reg} <= '0;
            dec_cnt_reg <= 11'h000;
            rd_cnt_reg <= 2'h0;
        end
        else if (mod_tick)
        begin
            i1_reg <= i1_reg + x_in;
            i2_reg <= i2_reg + i1_reg;
            i3_reg <= i3_reg + i2_reg;
            dec_cnt_reg <= out_evt ? 11'h000 : dec_cnt_reg + 11'h001; // R3
            if (out_evt)
            begin
                d1_reg <= i1_reg + x_in;
                d2a_reg <= i2_reg + i1_reg;
                d2b_reg <= y2a;
                d3a_reg <= i3_reg + i2_reg;
                d3b_reg <= y3a;
                d3c_reg <= y3b;
                if (rd_cnt_reg != 2'h3)
                    rd_cnt_reg <= rd_cnt_reg + 2'h1; // R5
            end
        end
    end

    // ----------------------------------------------------------------
    // Result output
    // ----------------------------------------------------------------
    dft_res_t res_reg;
    dft_res_t buf_out;
    logic strobe_reg;
    logic buf_in_ready;
    wire push_lost = strobe_reg && !buf_in_ready;

    assign out_strobe = strobe_reg;
    assign res_data = buf_out.data;
    assign res_chan = buf_out.chan;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            res_reg <= '0;
            strobe_reg <= 1'b0;
            last_reg <= 32'h0;
        end
        else
        begin
            strobe_reg <= out_evt && !restart; // R8
            if (out_evt)
                res_reg <= '{data: y_sel, filt: filt_sel, chan: chan};
            if (strobe_reg)
                last_reg <= res_reg.data;
        end
    end

    // A new overrun in the clearing cycle keeps the flag set
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ovr_reg <= 1'b0;
        else
            ovr_reg <= push_lost || (ovr_reg && !(wr_stat && hwdata[DFT_STAT_OVR_BIT]));
    end

    dft_buf #(.W($bits(dft_res_t)), .DEPTH(2)) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(strobe_reg),
        .in_ready(buf_in_ready),
        .in_data(res_reg),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(buf_out),
        .level(level)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mod_gap: assert property (@(posedge clk) disable iff (!rst_b)
        mod_tick && !restart ##1 !restart |-> (!mod_tick)[*8]) // R1
        else $error("modulator ticks too close together");
    a_decim_range: assert property (@(posedge clk) disable iff (!rst_b)
        decim_reg >= DFT_DECIM_MIN && decim_reg <= DFT_DECIM_MAX) // R2
        else $error("decimation ratio out of range");
    a_out_count: assert property (@(posedge clk) disable iff (!rst_b)
        out_evt |-> mod_tick && dec_cnt_reg == decim_reg - 11'h001) // R3
        else $error("result not at end of decimation period");
    a_filt_fixed: assert property (@(posedge clk) disable iff (!rst_b)
        filt_mode != DFT_FILT_AUTO |-> filt_sel == filt_mode) // R4
        else $error("fixed filter selection not honoured");
    a_auto_seq: assert property (@(posedge clk) disable iff (!rst_b)
        out_evt && filt_mode == DFT_FILT_AUTO && rd_cnt_reg > 2'h2
        |=> res_reg.filt == DFT_FILT_SINC3) // R5
        else $error("auto mode did not reach third-order filter");
    a_sign_fast: assert property (@(posedge clk) disable iff (!rst_b)
        out_evt && filt_sel == DFT_FILT_FAST |=> res_reg.data[31] == $past(y1[35])) // R6
        else $error("result sign differs from filter sign");
    a_samp_rate: assert property (@(posedge clk) disable iff (!rst_b || restart)
        gain <= DFT_GAIN_CODE_8 && samp_tick_reg |-> samp_cnt_reg == 9'h000) // R7
        else $error("sampling switch tick misplaced");
    a_strobe_once: assert property (@(posedge clk) disable iff (!rst_b)
        strobe_reg |=> !strobe_reg ##1 !strobe_reg) // R8
        else $error("valid strobe longer than one cycle");
    a_strobe_cause: assert property (@(posedge clk) disable iff (!rst_b)
        strobe_reg |-> $past(out_evt)) // R8
        else $error("valid strobe without a result");

    c_result: cover property (@(posedge clk) disable iff (!rst_b) strobe_reg);
    c_auto_s3: cover property (@(posedge clk) disable iff (!rst_b)
        strobe_reg && res_reg.filt == DFT_FILT_SINC3 && filt_mode == DFT_FILT_AUTO);
    c_overrun: cover property (@(posedge clk) disable iff (!rst_b) push_lost);
    c_gain32: cover property (@(posedge clk) disable iff (!rst_b)
        samp_tick_reg && gain > DFT_GAIN_CODE_16);

endmodule : dft_core
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the decimation filter and output timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dft_pkg::*;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, mod_bit, res_ready;
    logic mod_tick_out, samp_tick_out, out_strobe, res_valid;
    logic [31:0] haddr, hwdata, hrdata, res_data, rd, v;
    logic [1:0] htrans;
    logic [2:0] hsize, res_chan, ch;
    int error_cnt, num_checks, per, n;

    dft_core i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mod_bit(mod_bit), .mod_tick_out(mod_tick_out),
        .samp_tick_out(samp_tick_out), .out_strobe(out_strobe), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .res_chan(res_chan));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task stop_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    function automatic logic pick(input int s);
        logic [4:0] w;
        w = {hreadyout, res_valid, out_strobe, samp_tick_out, mod_tick_out};
        return w[s];
    endfunction : pick

    // Bounded wait for a high sample; p counts the edges taken
    task wait_hi(input int s, output int p);
        p = 0;
        do
        begin
            @(posedge clk);
            p++;
            if (p > 7000)
            begin
                error_cnt++;
                stop_test();
            end
        end
        while (pick(s) !== 1'b1);
    endtask : wait_hi

    // Third pulse gap only, so a setting change never mixes two rates
    task period(input int s, output int p);
        int q;
        wait_hi(s, q);
        wait_hi(s, q);
        wait_hi(s, p);
    endtask : period

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int q;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_hi(4, q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_hi(4, q);
        rd = hrdata;
    endtask : bus

    task wr_rd(input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp);
        bus(1'b1, a, wd);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : wr_rd

    task get_res(output logic [31:0] d);
        int q;
        wait_hi(2, q);
        wait_hi(3, q);
        chk(32'(out_strobe), 32'h0);
        chk(32'(res_chan), 32'(ch));
        d = res_data;
    endtask : get_res

    function automatic logic [31:0] mk(input int sp, input int f, input int g, input int c);
        return 32'(sp + (f << 1) + (g << 3) + (c << 6) + (1 << 9));
    endfunction : mk

    // Gain code 3 is read as the plain divisor rate
    function automatic logic [31:0] samp_exp(input int sp, input int g);
        return (32'(DFT_DIV_FAST) << sp) >> (g < 4 ? 0 : g == 4 ? 3 : 4);
    endfunction : samp_exp

    // Constant full-scale input at ratio 20: fast 20, sinc2 400, sinc3 8000 shifted by 4
    function automatic logic [31:0] filt_exp(input int f, input int k);
        int e;
        e = f < 3 ? f : k < 3 ? 0 : k == 3 ? 1 : 2;
        return e == 0 ? 32'h14 : e == 1 ? 32'h190 : 32'h1f4;
    endfunction : filt_exp

    task new_chan(input int f);
        ch = ch + 3'h1 + 3'($urandom % 7);
        bus(1'b1, DFT_OFS_CTRL, mk(0, f, 0, 32'(ch)));
    endtask : new_chan

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mod_bit = 1'b1;
        res_ready = 1'b1;
        ch = 3'h0;
        error_cnt = 0;
        num_checks = 0;
        v = $urandom(63);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, DFT_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, DFT_OFS_DECIM, 32'h0);
        chk(rd, 32'h14);
        bus(1'b0, DFT_OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(32'(res_valid), 32'h0);
        chk(32'(hresp), 32'h0);
        wr_rd(DFT_OFS_DECIM, 32'h13, 32'h14);
        wr_rd(DFT_OFS_DECIM, 32'h800, 32'h14);
        wr_rd(DFT_OFS_DECIM, 32'h7ff, 32'h7ff);
        v = 32'h14 + $urandom % 2028;
        wr_rd(DFT_OFS_DECIM, v, v);
        wr_rd(8'h10, 32'hffff, 32'h0);
        wr_rd(DFT_OFS_DECIM, 32'h14, 32'h14);
        for (int sp = 0; sp < 2; sp++)
        begin
            bus(1'b1, DFT_OFS_CTRL, mk(sp, 0, 0, 0));
            period(0, per);
            chk(32'(per), 32'(DFT_DIV_FAST) << sp);
            for (int g = 0; g < 8; g++)
            begin
                bus(1'b1, DFT_OFS_CTRL, mk(sp, 0, g, 0));
                period(1, per);
                chk(32'(per), samp_exp(sp, g));
            end
        end
        new_chan(0);
        period(2, per);
        chk(32'(per), 32'(DFT_DIV_FAST) * 32'h14);
        v = 32'h14 + $urandom % 21;
        bus(1'b1, DFT_OFS_DECIM, v);
        period(2, per);
        chk(32'(per), 32'(DFT_DIV_FAST) * v);
        bus(1'b1, DFT_OFS_DECIM, 32'h14);
        for (int f = 0; f < 4; f++)
        begin
            new_chan(f);
            for (int k = 1; k < 5; k++)
            begin
                get_res(v);
                if (f == 3 || k > f)
                    chk(v, filt_exp(f, k));
            end
        end
        mod_bit <= 1'b0;
        new_chan(0);
        get_res(v);
        get_res(v);
        chk(v, 32'hffffffec);
        // Stalled receiver: two results kept, the third dropped and flagged
        mod_bit <= 1'b1;
        new_chan(0);
        res_ready <= 1'b0;
        repeat (3) wait_hi(2, n);
        repeat (4) @(posedge clk);
        bus(1'b0, DFT_OFS_STATUS, 32'h0);
        chk(rd, 32'h5);
        res_ready <= 1'b1;
        repeat (2)
        begin
            @(posedge clk);
            chk(32'(res_valid), 32'h1);
            chk(res_data, 32'h14);
        end
        @(posedge clk);
        chk(32'(res_valid), 32'h0);
        bus(1'b0, DFT_OFS_RESULT, 32'h0);
        chk(rd, 32'h14);
        wr_rd(DFT_OFS_STATUS, 32'h1, 32'h0);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
